// *** hw/pmic_cfg_pkg.sv ***
package pmic_cfg_pkg;
  // Register subaddresses on the serial bus
  localparam logic [7:0] ADDR_PASSWORD   = 8'h10;
  localparam logic [7:0] ADDR_ENABLE_TWO = 8'h12;
  localparam logic [7:0] ADDR_CONFIG_ONE = 8'h13;
  localparam logic [7:0] ADDR_CONFIG_TWO = 8'h14;
  // Reset values
  localparam logic [7:0] RST_ENABLE_TWO  = 8'h00;
  localparam logic [7:0] RST_CONFIG_ONE  = 8'h4c;
  localparam logic [7:0] RST_CONFIG_TWO  = 8'hc0;
  // Writable bit masks; other bits are reserved and read zero
  localparam logic [7:0] MASK_ENABLE_TWO = 8'h7f;
  localparam logic [7:0] MASK_CONFIG_TWO = 8'hcf;
  // Nonvolatile-backed bits of the second configuration register
  localparam logic [7:0] NV_MASK_CONFIG_TWO = 8'hc0;
  // Enable register fields
  localparam int BIT_LINEAR_REG_ON  = 0;
  localparam int BIT_SWITCH_ONE_ON  = 1;
  localparam int BIT_SWITCH_TWO_ON  = 2;
  localparam int BIT_SWITCH_THREE_ON = 3;
  localparam int BIT_OUT_ONE        = 4;
  localparam int BIT_OUT_TWO        = 5;
  localparam int BIT_PIN_THREE      = 6;
  // First configuration register fields
  localparam int BIT_PB_LONG        = 7;
  localparam int BIT_OUT_TWO_BUF    = 6;
  localparam int BIT_PIN_PAIR_MODE  = 5;
  localparam int BIT_PG_DELAY_HI    = 4;
  localparam int BIT_PG_DELAY_LO    = 3;
  localparam int BIT_SUPERVISOR_TIGHT = 2;
  localparam int BIT_UNDERVOLTAGE_THRESHOLD_HI        = 1;
  localparam int BIT_UNDERVOLTAGE_THRESHOLD_LO        = 0;
  // Second configuration register fields
  localparam int BIT_WARM_RESET_SELECT = 7;
  // Timing
  localparam int CLK_HZ       = 40_000_000;
  localparam int PB_SHORT_S   = 8;
  localparam int PB_LONG_S    = 15;
  localparam int PG_DELAY0_MS = 10;
  localparam int PG_DELAY1_MS = 20;
  localparam int PG_DELAY2_MS = 50;
  localparam int PG_DELAY3_MS = 150;
  localparam int CYC_PER_MS   = CLK_HZ / 1000;
endpackage

// *** hw/pg_rise_delay.sv ***
`timescale 1ns/1ps
module pg_rise_delay #(
  parameter int CNT_W = 23,
  parameter int DLY0  = pmic_cfg_pkg::PG_DELAY0_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int DLY1  = pmic_cfg_pkg::PG_DELAY1_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int DLY2  = pmic_cfg_pkg::PG_DELAY2_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int DLY3  = pmic_cfg_pkg::PG_DELAY3_MS * pmic_cfg_pkg::CYC_PER_MS
) (
  input  wire logic       clk_sys_i,  // System clock
  input  wire logic       rst_i,      // Async reset, high
  input  wire logic       pg_raw_i,   // Undelayed power-good, synchronised
  input  wire logic [1:0] sel_i,      // Delay select code
  output logic            pg_o        // Delayed power-good
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] target;

  // Delay code to cycle count
  always_comb begin
    case (sel_i)
      2'h0:    target = CNT_W'(DLY0 - 1);
      2'h1:    target = CNT_W'(DLY1 - 1);
      2'h2:    target = CNT_W'(DLY2 - 1);
      default: target = CNT_W'(DLY3 - 1);
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      pg_o    <= 1'b0;
    end else if (!pg_raw_i) begin
      cnt_reg <= '0;
      pg_o    <= 1'b0;
    end else if (!pg_o) begin
      if (cnt_reg >= target) begin
        pg_o <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  AST_PG_FALL_FAST: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !pg_raw_i |=> !pg_o) else $error("power-good fall was delayed");
  AST_PG_RISE_SLOW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(pg_o) |-> cnt_reg >= target) else $error("power-good rose early");
endmodule

// *** hw/pmic_output_config_regs.sv ***
// What this block does
// - Pin three low at 0, released at 1
// - Pin three control ignored in warm-reset mode
// - Output two low at 0, released (open-drain) or driven high (push-pull) at 1
// - Pin one low at 0, released at 1
// - Pair mode ignores outputs one, two bits
// - Enable bits drive switches and regulator
// - Sequencer updates switch one, regulator bits
// - Button hold: 8 s or 15 s
// - Output two open-drain or push-pull
// - Pair mode: pin one drives output two
// - Normal mode: independent outputs, output two per its buffer bit
// - Only rising power-good is delayed
// - Tight supervisor limits enable overvoltage monitor
// - Config one at 0x13, reset 0x4c
// - Config two at 0x14, reset 0xc0
// - Warm-reset select turns pin three input
`timescale 1ns/1ps
module pmic_output_config_regs #(
  parameter logic [6:0] DEV_ADDR     = 7'h30,  // Bus address, plain default
  parameter logic [7:0] UNLOCK_KEY   = 8'h7d,  // Password scramble key, arbitrary
  parameter int         PB_SHORT_CYC = pmic_cfg_pkg::PB_SHORT_S * pmic_cfg_pkg::CLK_HZ,
  parameter int         PB_LONG_CYC  = pmic_cfg_pkg::PB_LONG_S * pmic_cfg_pkg::CLK_HZ,
  parameter int         PG_DLY0_CYC  = pmic_cfg_pkg::PG_DELAY0_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int         PG_DLY1_CYC  = pmic_cfg_pkg::PG_DELAY1_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int         PG_DLY2_CYC  = pmic_cfg_pkg::PG_DELAY2_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int         PG_DLY3_CYC  = pmic_cfg_pkg::PG_DELAY3_MS * pmic_cfg_pkg::CYC_PER_MS
) (
  input  wire logic       clk_sys_i,               // 40 MHz system clock
  input  wire logic       rst_i,                   // Power-on reset, async high
  input  wire logic       scl_i,                   // Serial clock pin
  input  wire logic       sda_i,                   // Serial data pin level
  output logic            sda_o,                   // Serial data drive value
  output logic            sda_oe_o,                // Serial data drive enable
  input  wire logic [7:0] nv_config_one_i,         // Stored defaults, config one
  input  wire logic [7:0] nv_config_two_i,         // Stored defaults, config two
  input  wire logic       seq_update_i,            // Sequencer update pulse
  input  wire logic       seq_switch_one_on_i,     // Sequenced switch one state
  input  wire logic       seq_linear_reg_on_i,     // Sequenced regulator state
  input  wire logic       general_pin_three_i,     // Pin three level
  output logic            general_pin_three_o,     // Pin three drive value
  output logic            general_pin_three_oe_o,  // Pin three drive enable
  input  wire logic       general_pin_one_i,       // Pin one level
  output logic            general_pin_one_o,       // Pin one drive value
  output logic            general_pin_one_oe_o,    // Pin one drive enable
  output logic            general_out_two_o,       // Output two drive value
  output logic            general_out_two_oe_o,    // Output two drive enable
  output logic            warm_reset_n_o,          // Warm reset to bucks, low
  output logic            switch_three_on_o,       // Load switch three enable
  output logic            switch_two_on_o,         // Load switch two enable
  output logic            switch_one_on_o,         // Load switch one enable
  output logic            linear_reg_on_o,         // Linear regulator enable
  input  wire logic       push_button_n_i,         // Push button, low pressed
  output logic            pb_reset_o,              // Button reset pulse
  input  wire logic       power_good_raw_i,        // Undelayed power-good
  output logic            power_good_o,            // Delayed power-good
  output logic            supervisor_tight_o,      // Tight falling limits
  output logic            ov_monitor_en_o,         // Overvoltage monitor enable
  output logic [1:0]      undervoltage_threshold_o // Lockout threshold code
);
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_SUB   = 9'h008,
    ST_SACK  = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } bus_state_t;

  // Pin synchronisers, two flops each
  logic [1:0] scl_sync_reg, sda_sync_reg, pin3_sync_reg, pin1_sync_reg;
  logic [1:0] pb_sync_reg, pg_sync_reg;
  logic       scl_d_reg, sda_d_reg;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync_reg  <= 2'h3;
      sda_sync_reg  <= 2'h3;
      pin3_sync_reg <= 2'h3;
      pin1_sync_reg <= 2'h3;
      pb_sync_reg   <= 2'h3;
      pg_sync_reg   <= 2'h0;
      scl_d_reg     <= 1'b1;
      sda_d_reg     <= 1'b1;
    end else begin
      scl_sync_reg  <= {scl_sync_reg[0], scl_i};
      sda_sync_reg  <= {sda_sync_reg[0], sda_i};
      pin3_sync_reg <= {pin3_sync_reg[0], general_pin_three_i};
      pin1_sync_reg <= {pin1_sync_reg[0], general_pin_one_i};
      pb_sync_reg   <= {pb_sync_reg[0], push_button_n_i};
      pg_sync_reg   <= {pg_sync_reg[0], power_good_raw_i};
      scl_d_reg     <= scl_sync_reg[1];
      sda_d_reg     <= sda_sync_reg[1];
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Register storage
  logic [7:0] enable_two_reg, config_one_reg, config_two_reg;
  logic       loaded_reg;
  logic       unlock_reg;
  logic [7:0] unlock_addr_reg;
  logic       wr_stb_reg;
  logic [7:0] wr_addr_reg, wr_data_reg;
  logic       prot_addr, wr_allowed;

  // Read mux; password and unmapped addresses read zero
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      pmic_cfg_pkg::ADDR_ENABLE_TWO: d = enable_two_reg;
      pmic_cfg_pkg::ADDR_CONFIG_ONE: d = config_one_reg;
      pmic_cfg_pkg::ADDR_CONFIG_TWO: d = config_two_reg;
      default:                       d = 8'h00;
    endcase
    return d;
  endfunction

  // Serial bus slave state machine
  bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg, sub_reg;
  logic       rw_reg, nack_reg, sda_low_reg;
  logic [7:0] rd_cur, rd_inc;
  // Read data for this and the next subaddress; a call result cannot be bit-selected
  always_comb begin
    rd_cur = read_mux(sub_reg);
    rd_inc = read_mux(sub_reg + 8'h01);
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      sub_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      nack_reg    <= 1'b0;
      sda_low_reg <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      // bus held off until defaults load
      if (!loaded_reg || bus_stop) begin
        state_reg   <= ST_IDLE;
        sda_low_reg <= 1'b0;
      end else if (bus_start) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_low_reg <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == ST_ADDR || state_reg == ST_SUB || state_reg == ST_WDATA) begin
          shift_reg   <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (state_reg == ST_RACK) begin
          nack_reg <= sda_s;
        end
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg      <= shift_reg[0];
                sda_low_reg <= 1'b1;
                state_reg   <= ST_AACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              tx_reg      <= rd_cur;
              sda_low_reg <= ~rd_cur[7];
              state_reg   <= ST_RDATA;
            end else begin
              sda_low_reg <= 1'b0;
              state_reg   <= ST_SUB;
            end
          end
          ST_SUB: begin
            if (bit_cnt_reg == 4'h8) begin
              sub_reg     <= shift_reg;
              sda_low_reg <= 1'b1;
              state_reg   <= ST_SACK;
            end
          end
          ST_WDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              wr_stb_reg  <= 1'b1;
              wr_addr_reg <= sub_reg;
              wr_data_reg <= shift_reg;
              sub_reg     <= sub_reg + 8'h01;
              sda_low_reg <= 1'b1;
              state_reg   <= ST_WACK;
            end
          end
          ST_SACK, ST_WACK: begin
            bit_cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
            state_reg   <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt_reg == 4'h7) begin
              sda_low_reg <= 1'b0;
              state_reg   <= ST_RACK;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              tx_reg      <= {tx_reg[6:0], 1'b0};
              sda_low_reg <= ~tx_reg[6];
            end
          end
          ST_RACK: begin
            // Master nack ends the read burst
            if (nack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              sub_reg     <= sub_reg + 8'h01;
              tx_reg      <= rd_inc;
              sda_low_reg <= ~rd_inc[7];
              bit_cnt_reg <= 4'h0;
              state_reg   <= ST_RDATA;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain data line: drive low only
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_low_reg;

  assign prot_addr = (wr_addr_reg == pmic_cfg_pkg::ADDR_ENABLE_TWO) ||
                     (wr_addr_reg == pmic_cfg_pkg::ADDR_CONFIG_ONE) ||
                     (wr_addr_reg == pmic_cfg_pkg::ADDR_CONFIG_TWO);
  // one unlock covers one matching write
  assign wr_allowed = unlock_reg && (unlock_addr_reg == wr_addr_reg);

  // Password unlock; any later non-password write consumes it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      unlock_reg      <= 1'b0;
      unlock_addr_reg <= 8'h00;
    end else if (wr_stb_reg) begin
      if (wr_addr_reg == pmic_cfg_pkg::ADDR_PASSWORD) begin
        unlock_reg      <= 1'b1;
        unlock_addr_reg <= wr_data_reg ^ UNLOCK_KEY;
      end else begin
        unlock_reg <= 1'b0;
      end
    end
  end

  // Register writes, default load and sequencer updates
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      enable_two_reg <= pmic_cfg_pkg::RST_ENABLE_TWO;
      config_one_reg <= pmic_cfg_pkg::RST_CONFIG_ONE;
      config_two_reg <= pmic_cfg_pkg::RST_CONFIG_TWO;
      loaded_reg     <= 1'b0;
    end else begin
      if (!loaded_reg) begin
        // stored defaults, first cycle after release
        config_one_reg <= nv_config_one_i;
        config_two_reg <= (config_two_reg & ~pmic_cfg_pkg::NV_MASK_CONFIG_TWO) |
                          (nv_config_two_i & pmic_cfg_pkg::NV_MASK_CONFIG_TWO);
        loaded_reg     <= 1'b1;
      end else if (wr_stb_reg && prot_addr && wr_allowed) begin
        case (wr_addr_reg)
          pmic_cfg_pkg::ADDR_ENABLE_TWO:
            enable_two_reg <= wr_data_reg & pmic_cfg_pkg::MASK_ENABLE_TWO;
          pmic_cfg_pkg::ADDR_CONFIG_ONE: config_one_reg <= wr_data_reg;
          pmic_cfg_pkg::ADDR_CONFIG_TWO:
            config_two_reg <= wr_data_reg & pmic_cfg_pkg::MASK_CONFIG_TWO;
          default: config_one_reg <= config_one_reg;
        endcase
      end
      if (seq_update_i) begin
        enable_two_reg[pmic_cfg_pkg::BIT_SWITCH_ONE_ON] <= seq_switch_one_on_i;
        enable_two_reg[pmic_cfg_pkg::BIT_LINEAR_REG_ON] <= seq_linear_reg_on_i;
      end
    end
  end

  logic warm_sel, pair_mode, out_two_pp, out_two_val;
  assign warm_sel  = config_two_reg[pmic_cfg_pkg::BIT_WARM_RESET_SELECT];
  assign pair_mode = config_one_reg[pmic_cfg_pkg::BIT_PIN_PAIR_MODE];
  assign out_two_pp = config_one_reg[pmic_cfg_pkg::BIT_OUT_TWO_BUF];
  // output two source by pair mode
  assign out_two_val = pair_mode ? pin1_sync_reg[1] : enable_two_reg[pmic_cfg_pkg::BIT_OUT_TWO];

  // Pin drivers, registered to keep them glitch free
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      general_pin_three_o    <= 1'b0;
      general_pin_three_oe_o <= 1'b0;
      general_pin_one_o      <= 1'b0;
      general_pin_one_oe_o   <= 1'b0;
      general_out_two_o      <= 1'b0;
      general_out_two_oe_o   <= 1'b0;
      warm_reset_n_o         <= 1'b1;
    end else begin
      // pin three output or warm-reset input
      general_pin_three_o    <= 1'b0;
      general_pin_three_oe_o <= ~warm_sel & ~enable_two_reg[pmic_cfg_pkg::BIT_PIN_THREE];
      warm_reset_n_o         <= warm_sel ? pin3_sync_reg[1] : 1'b1;
      general_pin_one_o      <= 1'b0;
      general_pin_one_oe_o   <= ~pair_mode & ~enable_two_reg[pmic_cfg_pkg::BIT_OUT_ONE];
      general_out_two_o      <= out_two_pp ? out_two_val : 1'b0;
      general_out_two_oe_o   <= out_two_pp ? 1'b1 : ~out_two_val;
    end
  end

  assign switch_three_on_o = enable_two_reg[pmic_cfg_pkg::BIT_SWITCH_THREE_ON];
  assign switch_two_on_o   = enable_two_reg[pmic_cfg_pkg::BIT_SWITCH_TWO_ON];
  assign switch_one_on_o   = enable_two_reg[pmic_cfg_pkg::BIT_SWITCH_ONE_ON];
  assign linear_reg_on_o   = enable_two_reg[pmic_cfg_pkg::BIT_LINEAR_REG_ON];
  assign supervisor_tight_o = config_one_reg[pmic_cfg_pkg::BIT_SUPERVISOR_TIGHT];
  assign ov_monitor_en_o    = config_one_reg[pmic_cfg_pkg::BIT_SUPERVISOR_TIGHT];
  assign undervoltage_threshold_o =
    config_one_reg[pmic_cfg_pkg::BIT_UNDERVOLTAGE_THRESHOLD_HI:pmic_cfg_pkg::BIT_UNDERVOLTAGE_THRESHOLD_LO];

  // Push-button hold timer; one pulse per press
  logic [29:0] pb_cnt_reg;
  logic [29:0] pb_target;
  logic        pb_fired_reg;
  assign pb_target = config_one_reg[pmic_cfg_pkg::BIT_PB_LONG] ?
                     30'(PB_LONG_CYC - 1) : 30'(PB_SHORT_CYC - 1);
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pb_cnt_reg   <= 30'h0;
      pb_fired_reg <= 1'b0;
      pb_reset_o   <= 1'b0;
    end else begin
      pb_reset_o <= 1'b0;
      if (pb_sync_reg[1]) begin
        pb_cnt_reg   <= 30'h0;
        pb_fired_reg <= 1'b0;
      end else if (!pb_fired_reg) begin
        if (pb_cnt_reg >= pb_target) begin
          pb_reset_o   <= 1'b1;
          pb_fired_reg <= 1'b1;
        end else begin
          pb_cnt_reg <= pb_cnt_reg + 30'h1;
        end
      end
    end
  end

  pg_rise_delay #(
    .CNT_W (23),
    .DLY0  (PG_DLY0_CYC),
    .DLY1  (PG_DLY1_CYC),
    .DLY2  (PG_DLY2_CYC),
    .DLY3  (PG_DLY3_CYC)
  ) u_pg_delay (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pg_raw_i  (pg_sync_reg[1]),
    .sel_i     (config_one_reg[pmic_cfg_pkg::BIT_PG_DELAY_HI:pmic_cfg_pkg::BIT_PG_DELAY_LO]),
    .pg_o      (power_good_o)
  );

  AST_PIN_THREE_LOW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!warm_sel && !enable_two_reg[6]) |=> (general_pin_three_oe_o && !general_pin_three_o))
    else $error("pin three not driven low");
  AST_PIN_THREE_WARM: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    warm_sel |=> !general_pin_three_oe_o) else $error("pin three driven in warm mode");
  AST_WARM_FOLLOW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (warm_sel && !pin3_sync_reg[1]) |=> !warm_reset_n_o) else $error("warm reset missed");
  AST_OUT_TWO_LOW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!pair_mode && !enable_two_reg[5]) |=> (general_out_two_oe_o && !general_out_two_o))
    else $error("output two not low");
  AST_PIN_ONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !pair_mode |=> (general_pin_one_oe_o == !$past(enable_two_reg[4])))
    else $error("pin one drive wrong");
  AST_PAIR_FOLLOW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pair_mode && out_two_pp) |=> (general_out_two_o == $past(pin1_sync_reg[1]))
    && !general_pin_one_oe_o) else $error("paired output two wrong");
  AST_BUF_OD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !out_two_pp |=> !general_out_two_o) else $error("open-drain drove high");
  AST_SEQ_WINS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (loaded_reg && seq_update_i) |=> (switch_one_on_o == $past(seq_switch_one_on_i))
    && (linear_reg_on_o == $past(seq_linear_reg_on_i))) else $error("sequencer lost");
  AST_LOCKED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (loaded_reg && wr_stb_reg && prot_addr && !wr_allowed && !seq_update_i)
    |=> $stable(enable_two_reg) && $stable(config_one_reg) && $stable(config_two_reg))
    else $error("locked register changed");
  AST_NV_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !loaded_reg |=> (config_one_reg == $past(nv_config_one_i)) && state_reg == ST_IDLE)
    else $error("defaults not loaded");
  AST_PB_TIME: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pb_reset_o |-> $past(pb_cnt_reg) >= $past(pb_target)) else $error("button fired early");
  AST_TIGHT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ov_monitor_en_o == config_one_reg[2]) else $error("overvoltage enable wrong");

  COV_WRITE: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_stb_reg && wr_allowed);
  COV_READ: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state_reg == ST_RACK ##1 state_reg == ST_RDATA);
  COV_PB: cover property (@(posedge clk_sys_i) disable iff (rst_i) pb_reset_o);
endmodule

// *** dv/i2c_host_model.sv ***
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h30  // Target bus address
) (
  input  wire logic clk_sys_i,  // System clock
  input  wire logic sda_oe_i,   // Device pulls data low
  output logic      scl_o,      // Serial clock
  output logic      sda_o       // Resolved data line
);
  logic low_reg = 1'b0;  // Host pulls data low
  // Pulled-up line, low while either party pulls
  assign sda_o = !(low_reg || sda_oe_i);
  initial scl_o = 1'b1;
  // Half bit of 8 clocks, double the minimum phase
  task automatic hw();
    repeat (8) @(posedge clk_sys_i);
    #2;
  endtask
  task automatic bx(input logic b, output logic s);
    low_reg = !b;
    hw();
    scl_o = 1'b1;
    hw();
    s = sda_o;
    scl_o = 1'b0;
  endtask
  task automatic by(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
    bx(m, a);
  endtask
  // Start (also repeated) or stop condition
  task automatic fr(input logic p);
    low_reg = p;
    hw();
    scl_o = 1'b1;
    hw();
    low_reg = !p;
    hw();
    if (!p) scl_o = 1'b0;
  endtask
  // One register write, or a read with final NACK
  task automatic xfer(input logic r, input logic [7:0] sub, dat, output logic [7:0] q);
    logic a;
    fr(1'b0);
    by({DEV_ADDR, 1'b0}, 1'b1, q, a);
    by(sub, 1'b1, q, a);
    if (r) begin
      fr(1'b0);
      by({DEV_ADDR, 1'b1}, 1'b1, q, a);
    end
    by(r ? 8'hff : dat, 1'b1, q, a);
    fr(1'b1);
  endtask
endmodule

// *** dv/pmic_output_config_regs_test.sv ***
`timescale 1ns/1ps
module pmic_output_config_regs_test;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, scl_i, sda_i, sda_o, sda_oe_o, seq_update_i = 1'b0;
  logic seq_switch_one_on_i = 1'b0, seq_linear_reg_on_i = 1'b0, general_pin_three_i = 1'b1;
  logic general_pin_three_o, general_pin_three_oe_o, general_pin_one_i = 1'b1;
  logic general_pin_one_o, general_pin_one_oe_o, general_out_two_o, general_out_two_oe_o;
  logic warm_reset_n_o, switch_three_on_o, switch_two_on_o, switch_one_on_o, linear_reg_on_o;
  logic push_button_n_i = 1'b1, pb_reset_o, power_good_raw_i = 1'b0, power_good_o;
  logic supervisor_tight_o, ov_monitor_en_o;
  logic [1:0] undervoltage_threshold_o;
  logic [7:0] nv_config_one_i = 8'h2d, nv_config_two_i = 8'h40, q;
  int miscompares = 0, compares = 0, n;
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  // Short counts keep the run brief
  pmic_output_config_regs #(.PB_SHORT_CYC(20), .PB_LONG_CYC(40), .PG_DLY0_CYC(5),
    .PG_DLY1_CYC(10), .PG_DLY2_CYC(15), .PG_DLY3_CYC(20)) pmic_output_config_regs_inst (.*);
  i2c_host_model i2c_host_model_inst (.clk_sys_i(clk_sys_i), .sda_oe_i(sda_oe_o),
    .scl_o(scl_i), .sda_o(sda_i));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #2;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] sub, exp, input string nm);
    i2c_host_model_inst.xfer(1'b1, sub, 8'h00, q);
    chk(nm, q, exp);
  endtask
  // Unlock first, since every protected write consumes it
  task automatic pw(input logic [7:0] sub, dat);
    i2c_host_model_inst.xfer(1'b0, pmic_cfg_pkg::ADDR_PASSWORD, sub ^ 8'h7d, q);
    i2c_host_model_inst.xfer(1'b0, sub, dat, q);
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence of register calls and pin checks
  initial begin
    cyc(4);
    chk("m", {4'h0, ov_monitor_en_o, supervisor_tight_o, undervoltage_threshold_o}, 8'h0c);
    rst_i = 1'b0;
    cyc(6);
    chk("m", {4'h0, ov_monitor_en_o, supervisor_tight_o, undervoltage_threshold_o}, 8'h0d);
    rd(8'h13, 8'h2d, "cfg1");
    rd(8'h14, 8'h40, "cfg2");
    i2c_host_model_inst.xfer(1'b0, 8'h12, 8'h3e, q);
    rd(8'h12, 8'h00, "locked");
    pw(8'h12, 8'h3e);
    cyc(2);
    chk("en", {4'h0, switch_three_on_o, switch_two_on_o, switch_one_on_o,
      linear_reg_on_o}, 8'h0e);
    chk("pin3", {5'h0, sda_o, general_pin_three_o, general_pin_three_oe_o}, 8'h01);
    general_pin_one_i = 1'b0;
    cyc(6);
    chk("pair0", {6'h0, general_pin_one_oe_o, general_out_two_oe_o}, 8'h01);
    general_pin_one_i = 1'b1;
    cyc(6);
    chk("pair1", {6'h0, general_pin_one_oe_o, general_out_two_oe_o}, 8'h00);
    // Paired push-pull with loose supervisor limits
    pw(8'h13, 8'h68);
    general_pin_one_i = 1'b0;
    cyc(6);
    chk("pp_pair0", {4'h0, ov_monitor_en_o, supervisor_tight_o, general_out_two_oe_o,
      general_out_two_o}, 8'h02);
    general_pin_one_i = 1'b1;
    cyc(6);
    chk("pp_pair1", {6'h0, general_out_two_oe_o, general_out_two_o}, 8'h03);
    pw(8'h13, 8'h4c);
    cyc(2);
    chk("ind", {4'h0, general_pin_one_o, general_pin_one_oe_o, general_out_two_oe_o,
      general_out_two_o}, 8'h03);
    seq_update_i = 1'b1;
    seq_linear_reg_on_i = 1'b1;
    cyc(1);
    seq_update_i = 1'b0;
    rd(8'h12, 8'h3d, "seq");
    pw(8'h14, 8'hc0);
    general_pin_three_i = 1'b0;
    cyc(6);
    chk("warm", {6'h0, general_pin_three_oe_o, warm_reset_n_o}, 8'h00);
    power_good_raw_i = 1'b1;
    n = 0;
    while (power_good_o !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    // Ten-cycle delay plus two synchroniser stages
    chk("pg_rise", 8'(n), 8'h0c);
    power_good_raw_i = 1'b0;
    cyc(4);
    chk("pg_fall", {7'h0, power_good_o}, 8'h00);
    // Short hold of 20 cycles plus two synchroniser stages
    push_button_n_i = 1'b0;
    n = 0;
    while (pb_reset_o !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("pb_hold", 8'(n), 8'h16);
    cyc(1);
    chk("pb_once", {7'h0, pb_reset_o}, 8'h00);
    push_button_n_i = 1'b1;
    results();
  end
endmodule
